// file: src/instr_sequencer.sv
// Instruction sequencer of the pipelined core: timing, branches, spaces, debug.
// Assumes fetch, execute and the debug link logic all run on CLK_SYS.
`timescale 1ns/1ps
module instr_sequencer
  import core_timing_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        OPCODE_VALID,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [15:0] INSTR_ADDR,
  input  wire logic [15:0] NEXT_ADDR,
  input  wire logic [7:0]  REL_OFFSET,
  input  wire logic        COND_TAKEN,
  input  wire mem_access_t MEM_ACCESS,
  input  wire logic [7:0]  PROG_STORE_CONTROL,
  input  wire logic        DBG_HALT_REQ,
  input  wire logic        DBG_RUN_REQ,
  input  wire logic        DBG_STEP_REQ,
  input  wire logic        BKPT_EN,
  input  wire logic [15:0] BKPT_ADDR,
  output logic             FETCH_READY,
  output logic             INSTR_DONE,
  output logic [1:0]       INSTR_BYTES,
  output logic             EXEC_NOP,
  output logic             BRANCH_LOAD,
  output logic [15:0]      BRANCH_TARGET,
  output logic             IRAM_SEL,
  output logic             SFR_SEL,
  output logic             FLASH_WR_STB,
  output logic             XRAM_WR_STB,
  output logic             XRAM_RD_STB,
  output logic             CODE_RD_STB,
  output logic             HALTED
);

  timing_t     lut_timing;
  timing_t     cur_q;
  seq_state_t  state_q;
  logic [3:0]  cnt_q;
  logic        ext_q;
  logic        ready_q;
  logic        halt_pend_q;
  logic        step_q;
  logic        resume_q;
  logic [15:0] target_q;
  logic        last_cycle;
  logic        taken_now;
  logic        finish;
  logic        bkpt_hit;
  logic        stop_take;
  logic        take;
  logic        halt_now;

  instr_timing_lut u_lut
  (
    .opcode (OPCODE),
    .timing (lut_timing)
  );

  // The table sets each count, plus one clock for a taken conditional branch, so the decode
  // never waits on a phase counter; that is what keeps short instructions at one clock each.
  assign last_cycle = (state_q == ST_EXEC) && (cnt_q == 4'd1);
  assign taken_now  = last_cycle && cur_q.cond && !ext_q && COND_TAKEN;
  assign finish     = last_cycle && !taken_now;
  // A resumed instruction must not trap again on the breakpoint it stopped at.
  assign bkpt_hit   = BKPT_EN && (INSTR_ADDR == BKPT_ADDR) && !resume_q;
  assign stop_take  = halt_pend_q || DBG_HALT_REQ || bkpt_hit || (step_q && !resume_q);
  assign take       = ready_q && OPCODE_VALID && !stop_take && !taken_now;
  assign halt_now   = ready_q && !take && !taken_now && (state_q != ST_HALT) &&
                      (halt_pend_q || DBG_HALT_REQ || (step_q && !resume_q) ||
                       (OPCODE_VALID && bkpt_hit));

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_q <= ST_RUN;
      cnt_q   <= CNT_RESET;
      ext_q   <= 1'b0;
      cur_q   <= TIMING_RESET;
    end
    else if (take)
    begin
      state_q <= ST_EXEC;
      cnt_q   <= lut_timing.cycles;
      ext_q   <= 1'b0;
      cur_q   <= lut_timing;
    end
    else if (taken_now)
    begin
      cnt_q <= 4'd1;
      ext_q <= 1'b1;
    end
    else if (halt_now)
      state_q <= ST_HALT;
    else if (state_q == ST_HALT && (DBG_RUN_REQ || DBG_STEP_REQ))
      state_q <= ST_RUN;
    else if (finish)
      state_q <= ST_RUN;
    else if (state_q == ST_EXEC)
      cnt_q <= cnt_q - 4'd1;
  end

  // Ready is predicted one cycle ahead so a one-clock instruction can follow
  // another back to back; a taken branch simply drops the offered opcode.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      ready_q <= 1'b1;
    else if (take)
      ready_q <= (lut_timing.cycles == 4'd1);
    else if (taken_now)
      ready_q <= 1'b1;
    else if (halt_now)
      ready_q <= 1'b0;
    else if (state_q == ST_HALT)
      ready_q <= DBG_RUN_REQ || DBG_STEP_REQ;
    else if (state_q == ST_EXEC)
      ready_q <= (cnt_q == 4'd2) || finish;
    else
      ready_q <= 1'b1;
  end

  // Debug control lives in its own flops and touches no application storage.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      halt_pend_q <= 1'b0;
      step_q      <= 1'b0;
      resume_q    <= 1'b0;
    end
    else
    begin
      if (halt_now)
        halt_pend_q <= 1'b0;
      else if (DBG_HALT_REQ)
        halt_pend_q <= 1'b1;
      if (state_q == ST_HALT && DBG_STEP_REQ)
      begin
        step_q   <= 1'b1;
        resume_q <= 1'b1;
      end
      else if (state_q == ST_HALT && DBG_RUN_REQ)
      begin
        step_q   <= 1'b0;
        resume_q <= 1'b1;
      end
      else if (take)
        resume_q <= 1'b0;
    end
  end

  // The offset is sign-extended and added to the following instruction.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      target_q <= ADDR_RESET;
    else if (take)
      target_q <= NEXT_ADDR + {{8{REL_OFFSET[7]}}, REL_OFFSET};
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      INSTR_DONE    <= 1'b0;
      INSTR_BYTES   <= 2'd0;
      EXEC_NOP      <= 1'b0;
      BRANCH_LOAD   <= 1'b0;
      BRANCH_TARGET <= ADDR_RESET;
    end
    else
    begin
      INSTR_DONE    <= finish;
      INSTR_BYTES   <= finish ? cur_q.bytes : 2'd0;
      EXEC_NOP      <= finish && cur_q.nop;
      BRANCH_LOAD   <= finish && (ext_q || cur_q.rel);
      BRANCH_TARGET <= target_q;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      IRAM_SEL <= 1'b0;
      SFR_SEL  <= 1'b0;
    end
    else
    begin
      IRAM_SEL <= MEM_ACCESS.valid &&
                  (MEM_ACCESS.indirect || MEM_ACCESS.addr < SFR_BASE_ADDR);
      SFR_SEL  <= MEM_ACCESS.valid && !MEM_ACCESS.indirect &&
                  (MEM_ACCESS.addr >= SFR_BASE_ADDR);
    end
  end

  // Flash strobes fire on the last clock so the address and data are settled.
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      FLASH_WR_STB <= 1'b0;
      XRAM_WR_STB  <= 1'b0;
      XRAM_RD_STB  <= 1'b0;
      CODE_RD_STB  <= 1'b0;
    end
    else
    begin
      FLASH_WR_STB <= finish && cur_q.movx_wr && PROG_STORE_CONTROL[PSC_WR_EN_BIT];
      XRAM_WR_STB  <= finish && cur_q.movx_wr && !PROG_STORE_CONTROL[PSC_WR_EN_BIT];
      XRAM_RD_STB  <= finish && cur_q.movx_rd;
      CODE_RD_STB  <= finish && cur_q.movc;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      HALTED <= 1'b0;
    else
      HALTED <= halt_now || (state_q == ST_HALT && !DBG_RUN_REQ && !DBG_STEP_REQ);
  end

  assign FETCH_READY = ready_q;

endmodule // instr_sequencer

// file: src/core_timing_pkg.sv
// Package for the pipelined core's instruction sequencer.
// Assumes one synchronous system clock and a synchronous active-high reset.
package core_timing_pkg;

  localparam int unsigned SYS_CLK_HZ       = 100_000_000;
  localparam int unsigned CORE_CLK_MAX_HZ  = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / SYS_CLK_HZ;

  localparam logic [3:0]  MAX_INSTR_CYCLES = 4'h8;
  localparam logic [7:0]  UNUSED_OPCODE    = 8'hA5;
  localparam logic [7:0]  NOP_OPCODE       = 8'h00;
  localparam int unsigned IRAM_BYTES       = 256;
  localparam int unsigned SFR_BYTES        = 128;
  localparam logic [7:0]  SFR_BASE_ADDR    = 8'h80;
  localparam int unsigned PSC_WR_EN_BIT    = 0;

  localparam logic [3:0]  CNT_RESET        = 4'h0;
  localparam logic [15:0] ADDR_RESET       = 16'h0000;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic       cond;
    logic       rel;
    logic       movx_wr;
    logic       movx_rd;
    logic       movc;
    logic       nop;
  } timing_t;

  localparam timing_t TIMING_RESET = '0;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_EXEC,
    ST_HALT
  } seq_state_t;

  typedef struct packed {
    logic       valid;
    logic       indirect;
    logic [7:0] addr;
  } mem_access_t;

endpackage

// file: src/instr_timing_lut.sv
// Opcode lookup giving length in bytes and execution time in system clocks.
// Assumes the opcode is stable from logic on the same clock.
`timescale 1ns/1ps
module instr_timing_lut
  import core_timing_pkg::*;
(
  input  wire logic [7:0] opcode,
  output timing_t         timing
);

  logic [3:0] hi;
  logic [3:0] lo;

  assign hi = opcode[7:4];
  assign lo = opcode[3:0];

  always_comb
  begin
    timing        = TIMING_RESET;
    timing.bytes  = 2'd2;
    timing.cycles = 4'd2;
    if (lo >= 4'h8)
    begin
      timing.bytes  = 2'd1;
      timing.cycles = 4'd1;
      case (hi)
        4'h7, 4'h8, 4'hA: begin timing.bytes = 2'd2; timing.cycles = 4'd2; end
        4'hB: begin timing.bytes = 2'd3; timing.cycles = 4'd3; timing.cond = 1'b1; end
        4'hD: begin timing.bytes = 2'd2; timing.cycles = 4'd2; timing.cond = 1'b1; end
        default: timing.cycles = 4'd1;
      endcase
    end
    else if (lo >= 4'h6)
    begin
      timing.bytes  = 2'd1;
      case (hi)
        4'h7, 4'h8, 4'hA: timing.bytes = 2'd2;
        4'hB: begin timing.bytes = 2'd3; timing.cycles = 4'd4; timing.cond = 1'b1; end
        default: timing.cycles = 4'd2;
      endcase
    end
    else
    begin
      case (opcode)
        8'h00, UNUSED_OPCODE: begin timing.bytes = 2'd1; timing.cycles = 4'd1; timing.nop = 1'b1; end
        8'h10, 8'h20, 8'h30, 8'hB5, 8'hB4, 8'hD5:
        begin
          timing.bytes  = 2'd3;
          timing.cycles = 4'd3;
          timing.cond   = 1'b1;
        end
        8'h40, 8'h50, 8'h60, 8'h70: timing.cond = 1'b1;
        8'h80: begin timing.cycles = 4'd3; timing.rel = 1'b1; end
        8'h90, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85: begin timing.bytes = 2'd3; timing.cycles = 4'd3; end
        8'hE0, 8'hE2, 8'hE3: begin timing.bytes = 2'd1; timing.cycles = 4'd3; timing.movx_rd = 1'b1; end
        8'hF0, 8'hF2, 8'hF3: begin timing.bytes = 2'd1; timing.cycles = 4'd3; timing.movx_wr = 1'b1; end
        8'h83, 8'h93: begin timing.bytes = 2'd1; timing.cycles = 4'd3; timing.movc = 1'b1; end
        8'h73: begin timing.bytes = 2'd1; timing.cycles = 4'd3; end
        8'h02, 8'h12: begin timing.bytes = 2'd3; timing.cycles = 4'd4; end
        8'h22, 8'h32: begin timing.bytes = 2'd1; timing.cycles = 4'd5; end
        8'h84: begin timing.bytes = 2'd1; timing.cycles = MAX_INSTR_CYCLES; end
        8'hA4: begin timing.bytes = 2'd1; timing.cycles = 4'd4; end
        8'h03, 8'h13, 8'h23, 8'h33, 8'hA3, 8'hB3, 8'hC3, 8'hD3,
        8'h04, 8'h14, 8'hC4, 8'hD4, 8'hE4, 8'hF4:
        begin
          timing.bytes  = 2'd1;
          timing.cycles = 4'd1;
        end
        default:
        begin
          if (lo == 4'h1)
            timing.cycles = 4'd3;
        end
      endcase
    end
  end

endmodule // instr_timing_lut

// file: test/fetch_model.sv
// Fetch side model that offers one opcode for each request pulse.
// Assumes the sequencer samples the offer on the rising clock edge.
`timescale 1ns/1ps
module fetch_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [7:0] op,
  input  wire logic       ready,
  input  wire logic       halted,
  output logic            valid,
  output logic [7:0]      opcode,
  output logic            took
);
  logic       held;
  logic [7:0] kept;
  always_ff @(posedge clk)
  begin
    took <= 1'b0;
    held <= 1'b0;
    if (rst)
    begin
      valid  <= 1'b0;
      opcode <= 8'h00;
      kept   <= 8'h00;
    end
    else if (req)
    begin
      valid  <= 1'b1;
      opcode <= op;
      kept   <= op;
    end
    else if (held && halted)
    begin
      // The core halted at that edge instead of taking the byte, so it is offered again.
      valid  <= 1'b1;
      opcode <= kept;
    end
    else if (valid && ready && !halted)
    begin
      // A released byte is inverted so that a stale opcode cannot match.
      valid  <= 1'b0;
      opcode <= ~opcode;
      took   <= 1'b1;
      held   <= 1'b1;
    end
  end
endmodule // fetch_model

// file: test/instr_sequencer_props.sv
// Checker for the instruction sequencer, watching its ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module instr_sequencer_props
  import core_timing_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire mem_access_t MEM_ACCESS,
  input wire logic [7:0]  PROG_STORE_CONTROL,
  input wire logic        DBG_HALT_REQ,
  input wire logic        DBG_RUN_REQ,
  input wire logic        FETCH_READY,
  input wire logic        INSTR_DONE,
  input wire logic [1:0]  INSTR_BYTES,
  input wire logic        EXEC_NOP,
  input wire logic        BRANCH_LOAD,
  input wire logic        IRAM_SEL,
  input wire logic        SFR_SEL,
  input wire logic        FLASH_WR_STB,
  input wire logic        XRAM_WR_STB,
  input wire logic        XRAM_RD_STB,
  input wire logic        CODE_RD_STB,
  input wire logic        HALTED
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic [3:0] busy_q;
  always_ff @(posedge CLK_SYS)
  begin
    if (RST || FETCH_READY || HALTED)
      busy_q <= 4'h0;
    else if (busy_q != 4'hF)
      busy_q <= busy_q + 4'h1;
  end
  property p_idle_bytes; !INSTR_DONE |-> INSTR_BYTES == 2'h0; endproperty
  a_idle_bytes: assert property (p_idle_bytes) else $error("bytes without retire");
  property p_done_bytes; INSTR_DONE |-> INSTR_BYTES != 2'h0; endproperty
  a_done_bytes: assert property (p_done_bytes) else $error("retire without bytes");
  property p_nop; EXEC_NOP |-> INSTR_DONE && INSTR_BYTES == 2'h1; endproperty
  a_nop: assert property (p_nop) else $error("nop retire wrong");
  // The strobes are flops, so the enable that launched them is one clock back.
  property p_flash; FLASH_WR_STB |-> $past(PROG_STORE_CONTROL[PSC_WR_EN_BIT]) && !XRAM_WR_STB;
  endproperty
  a_flash: assert property (p_flash) else $error("flash write while disabled");
  property p_xram; XRAM_WR_STB |-> !$past(PROG_STORE_CONTROL[PSC_WR_EN_BIT]); endproperty
  a_xram: assert property (p_xram) else $error("data write while flash enabled");
  property p_strobe; (FLASH_WR_STB || XRAM_WR_STB || XRAM_RD_STB || CODE_RD_STB)
    |-> INSTR_DONE && INSTR_BYTES == 2'h1; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe off retire");
  property p_sfr; MEM_ACCESS.valid && !MEM_ACCESS.indirect && MEM_ACCESS.addr >= SFR_BASE_ADDR
    |=> SFR_SEL && !IRAM_SEL; endproperty
  a_sfr: assert property (p_sfr) else $error("special space not selected");
  property p_iram; MEM_ACCESS.valid && (MEM_ACCESS.indirect || MEM_ACCESS.addr < SFR_BASE_ADDR)
    |=> IRAM_SEL && !SFR_SEL; endproperty
  a_iram: assert property (p_iram) else $error("data ram not selected");
  property p_halt; DBG_HALT_REQ && !HALTED && !DBG_RUN_REQ |-> ##[1:12] HALTED; endproperty
  a_halt: assert property (p_halt) else $error("halt not reached");
  property p_busy; busy_q <= 4'h7; endproperty
  a_busy: assert property (p_busy) else $error("instruction too long");
  c_branch: cover property (BRANCH_LOAD);
  c_flash: cover property (FLASH_WR_STB);
  c_sfr: cover property (SFR_SEL);
endmodule // instr_sequencer_props
bind instr_sequencer instr_sequencer_props u_props (.CLK_SYS(CLK_SYS), .RST(RST),
  .MEM_ACCESS(MEM_ACCESS), .PROG_STORE_CONTROL(PROG_STORE_CONTROL),
  .DBG_HALT_REQ(DBG_HALT_REQ), .DBG_RUN_REQ(DBG_RUN_REQ), .FETCH_READY(FETCH_READY),
  .INSTR_DONE(INSTR_DONE), .INSTR_BYTES(INSTR_BYTES), .EXEC_NOP(EXEC_NOP),
  .BRANCH_LOAD(BRANCH_LOAD), .IRAM_SEL(IRAM_SEL), .SFR_SEL(SFR_SEL),
  .FLASH_WR_STB(FLASH_WR_STB), .XRAM_WR_STB(XRAM_WR_STB), .XRAM_RD_STB(XRAM_RD_STB),
  .CODE_RD_STB(CODE_RD_STB), .HALTED(HALTED));

// file: test/pipelined_core_instr_timing_bench.sv
// Self-checking bench for the instruction sequencer with a fetch model.
// Assumes a 100 MHz clock and that every opcode is retired before the next.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
`define WAIT(x) begin n = 0; while ((x) !== 1'b1 && n < 30) begin @(posedge CLK_SYS); #1; \
  n++; end if (n >= 30) begin bad_count++; conclude(); end end
module pipelined_core_instr_timing_bench
  import core_timing_pkg::*;
;
  logic        CLK_SYS, RST, req, took, fvalid, COND_TAKEN, BKPT_EN;
  logic        FETCH_READY, INSTR_DONE, EXEC_NOP, BRANCH_LOAD, IRAM_SEL, SFR_SEL;
  logic        FLASH_WR_STB, XRAM_WR_STB, XRAM_RD_STB, CODE_RD_STB, HALTED;
  logic [1:0]  INSTR_BYTES;
  logic [2:0]  dbg;
  logic [7:0]  op_in, opcode, REL_OFFSET, PROG_STORE_CONTROL;
  logic [15:0] INSTR_ADDR, NEXT_ADDR, BKPT_ADDR, BRANCH_TARGET;
  mem_access_t MEM_ACCESS;
  int          n, bad_count, compares, seed_v;
  logic [7:0]  ops [15] = '{8'h00, 8'hA5, 8'h24, 8'h85, 8'hA4, 8'h84, 8'h22, 8'h93,
                            8'hE0, 8'hF0, 8'hE2, 8'hF2, 8'h80, 8'h60, 8'h20};
  fetch_model fm (.clk(CLK_SYS), .rst(RST), .req(req), .op(op_in), .ready(FETCH_READY),
    .halted(HALTED), .valid(fvalid), .opcode(opcode), .took(took));
  instr_sequencer dut (.CLK_SYS(CLK_SYS), .RST(RST), .OPCODE_VALID(fvalid), .OPCODE(opcode),
    .INSTR_ADDR(INSTR_ADDR), .NEXT_ADDR(NEXT_ADDR), .REL_OFFSET(REL_OFFSET),
    .COND_TAKEN(COND_TAKEN), .MEM_ACCESS(MEM_ACCESS), .PROG_STORE_CONTROL(PROG_STORE_CONTROL),
    .DBG_HALT_REQ(dbg[0]), .DBG_RUN_REQ(dbg[1]), .DBG_STEP_REQ(dbg[2]), .BKPT_EN(BKPT_EN),
    .BKPT_ADDR(BKPT_ADDR), .FETCH_READY(FETCH_READY), .INSTR_DONE(INSTR_DONE),
    .INSTR_BYTES(INSTR_BYTES), .EXEC_NOP(EXEC_NOP), .BRANCH_LOAD(BRANCH_LOAD),
    .BRANCH_TARGET(BRANCH_TARGET), .IRAM_SEL(IRAM_SEL), .SFR_SEL(SFR_SEL),
    .FLASH_WR_STB(FLASH_WR_STB), .XRAM_WR_STB(XRAM_WR_STB), .XRAM_RD_STB(XRAM_RD_STB),
    .CODE_RD_STB(CODE_RD_STB), .HALTED(HALTED));
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  // Bytes in the upper two bits, base clocks in the lower four.
  function automatic logic [5:0] info(input logic [7:0] o);
    case (o)
      8'h24, 8'h60: return {2'h2, 4'h2};
      8'h85, 8'h20: return {2'h3, 4'h3};
      8'hA4:        return {2'h1, 4'h4};
      8'h84:        return {2'h1, 4'h8};
      8'h22:        return {2'h1, 4'h5};
      8'h80:        return {2'h2, 4'h3};
      8'h93, 8'hE0, 8'hF0, 8'hE2, 8'hF2: return {2'h1, 4'h3};
      default:      return {2'h1, 4'h1};
    endcase
  endfunction
  task automatic conclude();
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic offer(input logic [7:0] o);
    @(posedge CLK_SYS);
    op_in <= o;
    req   <= 1'b1;
    @(posedge CLK_SYS);
    req <= 1'b0;
  endtask
  task automatic pulse(input int w);
    @(posedge CLK_SYS);
    dbg[w] <= 1'b1;
    @(posedge CLK_SYS);
    dbg[w] <= 1'b0;
  endtask
  task automatic run_op(input logic [7:0] o, input logic c);
    logic [5:0] e;
    logic       k, w, bl;
    mem_access_t m;
    e  = info(o);
    k  = (o == 8'h60) || (o == 8'h20);
    w  = (o == 8'hF0) || (o == 8'hF2);
    bl = (o == 8'h80) || (k && c);
    COND_TAKEN         <= c;
    REL_OFFSET         <= 8'($urandom);
    NEXT_ADDR          <= 16'($urandom);
    INSTR_ADDR         <= 16'($urandom);
    PROG_STORE_CONTROL <= 8'($urandom);
    MEM_ACCESS         <= mem_access_t'($urandom);
    offer(o);
    `WAIT(took)
    `WAIT(INSTR_DONE)
    `CHK("cycles", e[3:0] + {3'h0, k && c}, 4'(n))
    `CHK("bytes", e[5:4], INSTR_BYTES)
    `CHK("nop", o == 8'h00 || o == 8'hA5, EXEC_NOP)
    `CHK("code_rd", o == 8'h93, CODE_RD_STB)
    `CHK("xram_rd", o == 8'hE0 || o == 8'hE2, XRAM_RD_STB)
    `CHK("flash_wr", w && PROG_STORE_CONTROL[0], FLASH_WR_STB)
    `CHK("xram_wr", w && !PROG_STORE_CONTROL[0], XRAM_WR_STB)
    `CHK("branch", bl, BRANCH_LOAD)
    m = MEM_ACCESS;
    `CHK("iram", m.valid && (m.indirect || m.addr < SFR_BASE_ADDR), IRAM_SEL)
    `CHK("sfr", m.valid && !m.indirect && m.addr >= SFR_BASE_ADDR, SFR_SEL)
    if (bl)
      `CHK("target", NEXT_ADDR + {{8{REL_OFFSET[7]}}, REL_OFFSET}, BRANCH_TARGET)
  endtask
  initial
  begin
    {RST, req, op_in, dbg, COND_TAKEN, BKPT_EN, BKPT_ADDR, REL_OFFSET} = '0;
    {INSTR_ADDR, NEXT_ADDR, PROG_STORE_CONTROL, MEM_ACCESS} = '0;
    RST    = 1'b1;
    seed_v = $urandom(69);
    repeat (6) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    `CHK("ready", 1'b1, FETCH_READY)
    `CHK("halted", 1'b0, HALTED)
    foreach (ops[i])
    begin
      run_op(ops[i], 1'b1);
      run_op(ops[i], 1'b0);
    end
    repeat (40) run_op(ops[$urandom_range(14)], 1'($urandom));
    pulse(0);
    `WAIT(HALTED)
    offer(8'h00);
    repeat (3) @(posedge CLK_SYS);
    `CHK("refused", 1'b1, fvalid)
    pulse(2);
    `WAIT(INSTR_DONE)
    `WAIT(HALTED)
    pulse(1);
    `WAIT(!HALTED && !fvalid)
    // The first opcode after a resume passes any breakpoint, so one is spent here.
    run_op(8'h00, 1'b0);
    BKPT_EN    <= 1'b1;
    BKPT_ADDR  <= 16'h0123;
    INSTR_ADDR <= 16'h0123;
    offer(8'hA5);
    `WAIT(HALTED)
    @(posedge CLK_SYS);
    #1;
    `CHK("bkpt_hold", 1'b1, fvalid)
    pulse(1);
    `WAIT(INSTR_DONE)
    `CHK("resumed", 1'b0, HALTED)
    conclude();
  end
endmodule // pipelined_core_instr_timing_bench
